/* File: core/mbld_seq.sv */
// next-address selection for branch, loop and return opcodes
`timescale 1ns/1ns
`default_nettype none
`include "mbld_params.svh"

module mbld_seq
    import mbld_pkg::*;
#(
    parameter int W = `MBLD_ADDR_W,
    parameter int DEPTH = `MBLD_STACK_DEPTH
) (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ce,
    // microinstruction fields
    input wire logic [3:0] opcode,
    input wire logic condition_code_n,
    input wire logic condition_test_enable_n,
    input wire logic counter_load_n,
    input wire logic [W-1:0] pipeline_branch_field,
    // external vector source
    input wire logic [W-1:0] vector_addr,
    // to microprogram memory and vector source
    output logic [W-1:0] next_addr,
    output logic vector_enable_n,
    output logic [W-1:0] loop_count
);

    // ***************************************************
    // reset release
    // ***************************************************
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ***************************************************
    // state
    // ***************************************************
    typedef struct packed {
        mbld_op_t op;
        logic cc_n;
        logic ccen_n;
        logic rld_n;
        logic [W-1:0] br;
        logic [W-1:0] cnt;
        logic [W-1:0] micro_program_counter;
        logic [W-1:0] y;
        logic vect_n;
    } mbld_core_t;

    localparam int SPW = $clog2(DEPTH + 1);

    mbld_core_t c_q;
    mbld_core_t c_d;
    logic pass;
    logic cnt_nz;
    logic push;
    logic pop;
    logic [W-1:0] sel;
    logic [W-1:0] top;
    logic [SPW-1:0] sp;

    // ***************************************************
    // return stack
    // ***************************************************
    mbld_stack #(
        .W(W),
        .DEPTH(DEPTH)
    ) u_stack (
        .clk(ref_clk),
        .rst_n(rst_n),
        .ce(ce),
        .push(push),
        .pop(pop),
        .push_data(c_q.micro_program_counter),
        .top(top),
        .sp(sp)
    );

    // ***************************************************
    // next-address decode
    // ***************************************************
    // one choice shared by the subroutine and plain jump forms
    function automatic logic [W-1:0] reg_or_pipe(
        input logic ok,
        input logic [W-1:0] br_val,
        input logic [W-1:0] cnt_val
    );
        return ok ? br_val : cnt_val;
    endfunction

    // fields are captured one edge ahead so that the vector enable
    // can come from a flip-flop while the vector address is sampled
    always_comb begin
        c_d = c_q;
        push = 1'b0;
        pop = 1'b0;
        sel = c_q.micro_program_counter;
        pass = mbld_test_pass(c_q.cc_n, c_q.ccen_n);
        cnt_nz = (c_q.cnt != '0);
        case (c_q.op)
            cond_jump_pipeline_op: begin
                sel = pass ? c_q.br : c_q.micro_program_counter;
            end
            push_cond_load_op: begin
                push = 1'b1;
                sel = c_q.micro_program_counter;
                if (pass) begin
                    c_d.cnt = c_q.br;
                end
            end
            cond_subroutine_reg_or_pipe_op: begin
                push = 1'b1;
                sel = reg_or_pipe(pass, c_q.br, c_q.cnt);
            end
            cond_jump_vector_op: begin
                sel = pass ? vector_addr : c_q.micro_program_counter;
            end
            cond_jump_reg_or_pipe_op: begin
                sel = reg_or_pipe(pass, c_q.br, c_q.cnt);
            end
            repeat_from_stack_op: begin
                // bottom-tested, so a loaded n gives n+1 passes
                if (cnt_nz) begin
                    c_d.cnt = c_q.cnt - 1'b1;
                    sel = top;
                end else begin
                    sel = c_q.micro_program_counter;
                    pop = 1'b1;
                end
            end
            repeat_from_pipe_op: begin
                if (cnt_nz) begin
                    c_d.cnt = c_q.cnt - 1'b1;
                    sel = c_q.br;
                end else begin
                    sel = c_q.micro_program_counter;
                end
            end
            cond_return_op: begin
                if (pass) begin
                    sel = top;
                    pop = 1'b1;
                end else begin
                    sel = c_q.micro_program_counter;
                end
            end
            default: begin
                // opcodes outside this decoder just continue
                sel = c_q.micro_program_counter;
            end
        endcase
        if (!c_q.rld_n) begin
            c_d.cnt = c_q.br;
        end
        c_d.y = sel;
        c_d.micro_program_counter = sel + 1'b1;
        c_d.op = mbld_op_t'(opcode);
        c_d.cc_n = condition_code_n;
        c_d.ccen_n = condition_test_enable_n;
        c_d.rld_n = counter_load_n;
        c_d.br = pipeline_branch_field;
        c_d.vect_n = (opcode != `MBLD_OP_CJV);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            c_q.op <= mbld_op_t'(`MBLD_RST_OP);
            c_q.cc_n <= 1'b1;
            c_q.ccen_n <= 1'b1;
            c_q.rld_n <= 1'b1;
            c_q.br <= `MBLD_RST_ADDR;
            c_q.cnt <= `MBLD_RST_CNT;
            c_q.micro_program_counter <= `MBLD_RST_ADDR;
            c_q.y <= `MBLD_RST_ADDR;
            c_q.vect_n <= 1'b1;
        end else if (ce) begin
            c_q <= c_d;
        end
    end

    assign next_addr = c_q.y;
    assign vector_enable_n = c_q.vect_n;
    assign loop_count = c_q.cnt;

    // ***************************************************
    // assertions
    // ***************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    logic step;
    assign step = ce && c_q.rld_n;

    cjp_target_a: assert property (
        ce && c_q.op == cond_jump_pipeline_op
        |=> next_addr == ($past(pass) ? $past(c_q.br) : $past(c_q.micro_program_counter))
    ) else $error("pipeline jump took the wrong address");

    push_stack_a: assert property (
        ce && c_q.op == push_cond_load_op && sp != SPW'(DEPTH)
        |=> sp == $past(sp) + 1'b1 && top == $past(c_q.micro_program_counter)
            && next_addr == $past(c_q.micro_program_counter)
    ) else $error("push opcode did not push next address");

    push_load_a: assert property (
        step && c_q.op == push_cond_load_op
        |=> loop_count == ($past(pass) ? $past(c_q.br)
                                       : $past(c_q.cnt))
    ) else $error("conditional count load wrong");

    cond_subroutine_reg_or_pipe_op_sel_a: assert property (
        ce && c_q.op == cond_subroutine_reg_or_pipe_op
        && sp != SPW'(DEPTH)
        |=> next_addr == ($past(pass) ? $past(c_q.br) : $past(c_q.cnt))
            && sp == $past(sp) + 1'b1
            && top == $past(c_q.micro_program_counter)
    ) else $error("subroutine via register or pipe wrong");

    vect_en_a: assert property (
        ce && c_q.op == cond_jump_vector_op
        |-> vector_enable_n == 1'b0
            ##1 next_addr == ($past(pass) ? $past(vector_addr)
                                          : $past(c_q.micro_program_counter))
    ) else $error("vector jump or vector enable wrong");

    jrp_nopush_a: assert property (
        ce && c_q.op == cond_jump_reg_or_pipe_op
        |=> sp == $past(sp)
            && next_addr == ($past(pass) ? $past(c_q.br)
                                         : $past(c_q.cnt))
    ) else $error("register or pipe jump touched the stack");

    repeat_from_stack_op_loop_a: assert property (
        step && c_q.op == repeat_from_stack_op && cnt_nz
        |=> loop_count == $past(c_q.cnt) - 1'b1
            && next_addr == $past(top) && sp == $past(sp)
    ) else $error("stack repeat loop step wrong");

    repeat_from_stack_op_exit_a: assert property (
        step && c_q.op == repeat_from_stack_op && !cnt_nz && sp != '0
        |=> loop_count == '0 && next_addr == $past(c_q.micro_program_counter)
            && sp == $past(sp) - 1'b1
    ) else $error("stack repeat exit wrong");

    repeat_from_pipe_op_a: assert property (
        step && c_q.op == repeat_from_pipe_op
        |=> sp == $past(sp)
            && next_addr == ($past(cnt_nz) ? $past(c_q.br)
                                           : $past(c_q.micro_program_counter))
    ) else $error("pipe repeat wrong");

    cond_return_op_a: assert property (
        ce && c_q.op == cond_return_op && sp != '0
        |=> next_addr == ($past(pass) ? $past(top) : $past(c_q.micro_program_counter))
            && sp == ($past(pass) ? $past(sp) - 1'b1 : $past(sp))
    ) else $error("conditional return wrong");

    force_pass_a: assert property (
        pass == (c_q.ccen_n || !c_q.cc_n)
    ) else $error("test result wrong");

    ld_override_a: assert property (
        ce && !c_q.rld_n |=> loop_count == $past(c_q.br)
    ) else $error("load input did not override count");

    upc_inc_a: assert property (
        ce |=> c_q.micro_program_counter == next_addr + 1'b1
    ) else $error("program counter not address plus one");

    // the stack is frozen with everything else
    freeze_a: assert property (
        !ce |=> $stable(next_addr) && $stable(loop_count)
            && $stable(vector_enable_n) && $stable(sp) && $stable(top)
    ) else $error("state moved while clock enable was low");

    vect_cap_a: assert property (
        ce |=> vector_enable_n == ($past(opcode) != `MBLD_OP_CJV)
    ) else $error("vector enable does not follow the opcode");

    repeat_from_pipe_op_count_a: assert property (
        step && c_q.op == repeat_from_pipe_op
        |=> loop_count == ($past(cnt_nz) ? $past(c_q.cnt) - 1'b1 : '0)
    ) else $error("pipe repeat count wrong");

    cont_hold_a: assert property (
        step && c_q.op == continue_op
        |=> next_addr == $past(c_q.micro_program_counter) && sp == $past(sp)
            && loop_count == $past(c_q.cnt)
    ) else $error("continue did not step on");

    pop_empty_a: assert property (
        ce && pop && sp == '0 |=> sp == '0 && top == '0
    ) else $error("pop on an empty stack moved the pointer");

    loop_taken_c: cover property (
        step && c_q.op == repeat_from_stack_op && cnt_nz
    );
    loop_exit_c: cover property (
        step && c_q.op == repeat_from_stack_op && !cnt_nz
    );
    vector_pass_c: cover property (
        ce && c_q.op == cond_jump_vector_op && pass
    );
    return_pass_c: cover property (
        ce && c_q.op == cond_return_op && pass && sp != '0
    );
    push_pass_c: cover property (
        step && c_q.op == push_cond_load_op && pass
    );

endmodule
`default_nettype wire

/* File: core/mbld_params.svh */
// constants of the branch and loop next-address decoder
`ifndef MBLD_PARAMS_SVH
`define MBLD_PARAMS_SVH

// ***************************************************
// widths and sizes
// ***************************************************
`define MBLD_ADDR_W 12
`define MBLD_STACK_DEPTH 9

// ***************************************************
// opcode codes
// ***************************************************
`define MBLD_OP_CJP 4'h3
`define MBLD_OP_PUSH 4'h4
`define MBLD_OP_COND_SUBROUTINE_REG_OR_PIPE_OP 4'h5
`define MBLD_OP_CJV 4'h6
`define MBLD_OP_JRP 4'h7
`define MBLD_OP_REPEAT_FROM_STACK_OP 4'h8
`define MBLD_OP_REPEAT_FROM_PIPE_OP 4'h9
`define MBLD_OP_COND_RETURN_OP 4'hA
`define MBLD_OP_CONT 4'hE

// ***************************************************
// reset values
// ***************************************************
`define MBLD_RST_ADDR 12'h000
`define MBLD_RST_CNT 12'h000
`define MBLD_RST_OP 4'hE

`endif

/* File: core/mbld_pkg.sv */
// types and shared helpers of the next-address decoder
`include "mbld_params.svh"

package mbld_pkg;

    typedef enum logic [3:0] {
        cond_jump_pipeline_op = `MBLD_OP_CJP,
        push_cond_load_op = `MBLD_OP_PUSH,
        cond_subroutine_reg_or_pipe_op = `MBLD_OP_COND_SUBROUTINE_REG_OR_PIPE_OP,
        cond_jump_vector_op = `MBLD_OP_CJV,
        cond_jump_reg_or_pipe_op = `MBLD_OP_JRP,
        repeat_from_stack_op = `MBLD_OP_REPEAT_FROM_STACK_OP,
        repeat_from_pipe_op = `MBLD_OP_REPEAT_FROM_PIPE_OP,
        cond_return_op = `MBLD_OP_COND_RETURN_OP,
        continue_op = `MBLD_OP_CONT
    } mbld_op_t;

    // a high test enable forces a pass
    function automatic logic mbld_test_pass(input logic cc_n,
                                            input logic ccen_n);
        return ccen_n | ~cc_n;
    endfunction

endpackage

/* File: core/mbld_stack.sv */
// return-address stack with pointer
`timescale 1ns/1ns
`default_nettype none
`include "mbld_params.svh"

module mbld_stack
    import mbld_pkg::*;
#(
    parameter int W = `MBLD_ADDR_W,
    parameter int DEPTH = `MBLD_STACK_DEPTH
) (
    // clock, reset and enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // stack control
    input wire logic push,
    input wire logic pop,
    input wire logic [W-1:0] push_data,
    // stack state
    output logic [W-1:0] top,
    output logic [$clog2(DEPTH+1)-1:0] sp
);
    localparam int SPW = $clog2(DEPTH + 1);
    localparam logic [SPW-1:0] FULL = SPW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [SPW-1:0] sp;
    } mbld_stack_st_t;

    mbld_stack_st_t s_q;
    mbld_stack_st_t s_d;

    always_comb begin
        s_d = s_q;
        if (push) begin
            // a push onto a full stack overwrites the top entry
            if (s_q.sp != FULL) begin
                s_d.mem[s_q.sp] = push_data;
                s_d.sp = SPW'(s_q.sp + 1'b1);
            end else begin
                s_d.mem[DEPTH-1] = push_data;
            end
        end else if (pop && s_q.sp != '0) begin
            s_d.sp = SPW'(s_q.sp - 1'b1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // empty stack reads as zero
    assign top = (s_q.sp == '0) ? '0 : s_q.mem[SPW'(s_q.sp - 1'b1)];
    assign sp = s_q.sp;

endmodule
`default_nettype wire

/* File: test/mbld_vec_src.sv */
// vector source model driving the branch address in vector jumps
`timescale 1ns/1ns
`default_nettype none
module mbld_vec_src #(
    parameter logic [11:0] VEC = 12'h5A5
) (
    // clock
    input wire logic ref_clk,
    // enable and address
    input wire logic vector_enable_n,
    output logic [11:0] vector_addr
);
    // off the bus the lines keep changing, so a stray sample shows up
    logic [11:0] junk_q = 12'h0F0;
    always @(posedge ref_clk) begin
        junk_q <= ~junk_q;
    end
    assign vector_addr = vector_enable_n ? junk_q : VEC;
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench of the branch and loop next-address decoder
`timescale 1ns/1ns
`default_nettype none
module testbench;
    typedef struct packed {
        logic [3:0] op;
        logic cc_n;
        logic ccen_n;
        logic ld_n;
        logic [11:0] br;
        logic [11:0] addr;
        logic [11:0] cnt;
    } mbld_tb_row_t;
    localparam int NR = 23;
    // ****************************************
    // program: op, cc_n, ccen_n, ld_n, branch, next, count
    // ****************************************
    // results run back to back, so each row depends on the rows above it
    localparam mbld_tb_row_t ROWS [NR] = '{
        '{4'h3, 1'h0, 1'h0, 1'h1, 12'h120, 12'h120, 12'h000},
        '{4'h3, 1'h1, 1'h0, 1'h1, 12'h300, 12'h121, 12'h000},
        '{4'h4, 1'h1, 1'h0, 1'h1, 12'h055, 12'h122, 12'h000},
        '{4'h4, 1'h0, 1'h0, 1'h1, 12'h002, 12'h123, 12'h002},
        '{4'h8, 1'h1, 1'h0, 1'h1, 12'h000, 12'h123, 12'h001},
        '{4'h8, 1'h1, 1'h0, 1'h1, 12'h000, 12'h123, 12'h000},
        '{4'h8, 1'h1, 1'h0, 1'h1, 12'h000, 12'h124, 12'h000},
        '{4'hA, 1'h1, 1'h0, 1'h1, 12'h000, 12'h125, 12'h000},
        '{4'hA, 1'h1, 1'h1, 1'h1, 12'h000, 12'h122, 12'h000},
        '{4'hE, 1'h1, 1'h0, 1'h0, 12'h2A0, 12'h123, 12'h2A0},
        '{4'h5, 1'h1, 1'h0, 1'h1, 12'h3C0, 12'h2A0, 12'h2A0},
        '{4'h5, 1'h0, 1'h0, 1'h1, 12'h3C0, 12'h3C0, 12'h2A0},
        '{4'h7, 1'h1, 1'h0, 1'h1, 12'h011, 12'h2A0, 12'h2A0},
        '{4'h7, 1'h0, 1'h0, 1'h1, 12'h011, 12'h011, 12'h2A0},
        '{4'hA, 1'h0, 1'h0, 1'h1, 12'h000, 12'h2A1, 12'h2A0},
        '{4'h6, 1'h0, 1'h0, 1'h1, 12'h000, 12'h5A5, 12'h2A0},
        '{4'h6, 1'h1, 1'h0, 1'h1, 12'h000, 12'h5A6, 12'h2A0},
        '{4'h9, 1'h1, 1'h0, 1'h1, 12'h077, 12'h077, 12'h29F},
        '{4'h9, 1'h1, 1'h0, 1'h0, 12'h000, 12'h000, 12'h000},
        '{4'h9, 1'h1, 1'h0, 1'h1, 12'h077, 12'h001, 12'h000},
        '{4'hA, 1'h1, 1'h1, 1'h1, 12'h000, 12'h124, 12'h000},
        '{4'hE, 1'h1, 1'h0, 1'h1, 12'h000, 12'h125, 12'h000},
        '{4'hE, 1'h1, 1'h0, 1'h1, 12'h000, 12'h126, 12'h000}
    };
    logic ref_clk = 1'h0;
    logic rstn = 1'h0;
    logic ce = 1'h0;
    logic [3:0] opcode = 4'hE;
    logic condition_code_n = 1'h1;
    logic condition_test_enable_n = 1'h0;
    logic counter_load_n = 1'h1;
    logic [11:0] pipeline_branch_field = 12'h000;
    logic [11:0] vector_addr;
    logic [11:0] next_addr;
    logic [11:0] loop_count;
    logic vector_enable_n;
    int mismatches = 0;
    int comparisons = 0;
    mbld_tb_row_t r;

    always #20 ref_clk = ~ref_clk;

    mbld_seq mbld_seq_inst (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .ce(ce),
        .opcode(opcode),
        .condition_code_n(condition_code_n),
        .condition_test_enable_n(condition_test_enable_n),
        .counter_load_n(counter_load_n),
        .pipeline_branch_field(pipeline_branch_field),
        .vector_addr(vector_addr),
        .next_addr(next_addr),
        .vector_enable_n(vector_enable_n),
        .loop_count(loop_count)
    );

    mbld_vec_src #(.VEC(12'h5A5)) mbld_vec_src_inst (
        .ref_clk(ref_clk),
        .vector_enable_n(vector_enable_n),
        .vector_addr(vector_addr)
    );

    // ****************************************
    // tasks
    // ****************************************
    task automatic check12(input logic [11:0] got, input logic [11:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t ns: flag %b, expected %b", $time, got, exp);
        end
    endtask

    task automatic drive(input mbld_tb_row_t d);
        opcode <= d.op;
        condition_code_n <= d.cc_n;
        condition_test_enable_n <= d.ccen_n;
        counter_load_n <= d.ld_n;
        pipeline_branch_field <= d.br;
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ****************************************
    // sequence
    // ****************************************
    initial begin
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk);
        check12(next_addr, 12'h000);
        check12(loop_count, 12'h000);
        check1(vector_enable_n, 1'h1);
        @(posedge ref_clk);
        rstn <= 1'h1;
        // ce stays low until the reset copy is released
        repeat (2) @(posedge ref_clk);
        for (int i = 0; i < NR; i++) begin
            @(posedge ref_clk);
            drive(ROWS[i]);
            ce <= 1'h1;
            @(negedge ref_clk);
            if (i >= 1) begin
                r = ROWS[i-1];
                check1(vector_enable_n, r.op !== 4'h6);
            end
            if (i >= 2) begin
                r = ROWS[i-2];
                check12(next_addr, r.addr);
                check12(loop_count, r.cnt);
            end
        end
        // frozen clock enable: a vector jump with load must not act
        @(posedge ref_clk);
        ce <= 1'h0;
        r = '{4'h6, 1'h0, 1'h0, 1'h0, 12'h7FF, 12'h000, 12'h000};
        drive(r);
        repeat (3) begin
            @(negedge ref_clk);
            check12(next_addr, 12'h125);
            check12(loop_count, 12'h000);
            check1(vector_enable_n, 1'h1);
        end
        // reset in mid-run clears the outputs without a clock edge
        @(posedge ref_clk);
        rstn <= 1'h0;
        #1;
        check12(next_addr, 12'h000);
        check12(loop_count, 12'h000);
        check1(vector_enable_n, 1'h1);
        // second release: program counter and stack restart from zero
        @(posedge ref_clk);
        rstn <= 1'h1;
        repeat (3) @(posedge ref_clk);
        r = '{4'hA, 1'h1, 1'h1, 1'h1, 12'h000, 12'h000, 12'h000};
        drive(r);
        ce <= 1'h1;
        @(posedge ref_clk);
        r.op = 4'hE;
        drive(r);
        @(negedge ref_clk);
        check12(next_addr, 12'h000);
        @(negedge ref_clk);
        check12(next_addr, 12'h000);
        check12(loop_count, 12'h000);
        @(negedge ref_clk);
        check12(next_addr, 12'h001);
        check1(vector_enable_n, 1'h1);
        results();
    end

    initial begin
        #(40 * 2000);
        mismatches++;
        results();
    end
endmodule
`default_nettype wire
